// ### hw/pwmact_top.sv
// pwm output action logic for three generators with an axi4-lite register slave
`timescale 1ns/1ns
`default_nettype none
module pwmact_top
    import pwmact_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [ADDR_W-1:0]         s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire pwmact_evt_t [NUM_GEN-1:0] gen_events,
    output logic [NUM_GEN-1:0]             generator_output_a,
    output logic [NUM_GEN-1:0]             generator_output_b
);

    typedef struct packed {
        logic [NUM_GEN-1:0][CTL_W-1:0] act_a;
        logic [NUM_GEN-1:0][CTL_W-1:0] act_b;
        logic [NUM_GEN-1:0]            mode;
        logic [NUM_GEN-1:0]            out_a;
        logic [NUM_GEN-1:0]            out_b;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          rvalid;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
    } pwmact_state_t;

    pwmact_state_t q;
    pwmact_state_t d;
    logic          wr_go;
    logic          rd_go;

    ////////////////////////////////////////////////////////////////////////////////
    // helper functions

    function automatic logic pwmact_apply(input logic [1:0] act, input logic cur);
        unique case (act)
            ACT_NONE: return cur;
            ACT_INV:  return ~cur;
            ACT_LOW:  return 1'b0;
            ACT_HIGH: return 1'b1;
        endcase
    endfunction : pwmact_apply

    // picks the single winning action; b_first selects the B-output ordering
    function automatic logic pwmact_next(input logic [CTL_W-1:0] ctl, input pwmact_evt_t ev,
                                         input logic updown, input logic b_first, input logic cur);
        logic       up;
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic [1:0] act;
        // up compares exist only in up/down mode; down-only makes every compare a down one
        up    = updown && !ev.down;
        act_a = up ? ctl[FLD_AU +: 2] : ctl[FLD_AD +: 2];
        act_b = up ? ctl[FLD_BU +: 2] : ctl[FLD_BD +: 2];
        act   = ACT_NONE;
        // zero, then load, beat the comparators
        if (ev.zero) begin
            act = ctl[FLD_ZERO +: 2];
        end else if (ev.load) begin
            act = ctl[FLD_LOAD +: 2];
        end else if (ev.cmp_a && ev.cmp_b) begin
            act = b_first ? act_b : act_a;
        end else if (ev.cmp_a) begin
            act = act_a;
        end else if (ev.cmp_b) begin
            act = act_b;
        end
        return pwmact_apply(act, cur);
    endfunction : pwmact_next

    // reserved bits above the fields are dropped on write
    function automatic logic [CTL_W-1:0] pwmact_merge(input logic [CTL_W-1:0] old,
                                                      input logic [31:0] wd, input logic [3:0] ws);
        logic [CTL_W-1:0] r;
        r = old;
        if (ws[0]) begin
            r[7:0] = wd[7:0];
        end
        if (ws[1]) begin
            r[CTL_W-1:8] = wd[CTL_W-1:8];
        end
        return r;
    endfunction : pwmact_merge

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    // write address and data are taken together so no skid storage is needed
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    assign rd_go         = s_axi_arvalid && !q.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    always_comb begin
        d = q;
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp  = RESP_SLVERR;
            if (s_axi_awaddr == ADDR_W'(OFF_MODE)) begin
                d.bresp = RESP_OKAY;
                if (s_axi_wstrb[0]) begin
                    d.mode = s_axi_wdata[NUM_GEN-1:0];
                end
            end else if (s_axi_awaddr == ADDR_W'(OFF_STATUS)) begin
                d.bresp = RESP_OKAY;
            end
            for (int g = 0; g < NUM_GEN; g++) begin
                if (s_axi_awaddr == ADDR_W'(OFF_GEN_A[g])) begin
                    d.bresp    = RESP_OKAY;
                    d.act_a[g] = pwmact_merge(q.act_a[g], s_axi_wdata, s_axi_wstrb);
                end
                if (s_axi_awaddr == ADDR_W'(OFF_GEN_B[g])) begin
                    d.bresp    = RESP_OKAY;
                    d.act_b[g] = pwmact_merge(q.act_b[g], s_axi_wdata, s_axi_wstrb);
                end
            end
        end
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_SLVERR;
            d.rdata  = 32'h0000_0000;
            if (s_axi_araddr == ADDR_W'(OFF_MODE)) begin
                d.rresp = RESP_OKAY;
                d.rdata = {29'h0000_0000, q.mode};
            end else if (s_axi_araddr == ADDR_W'(OFF_STATUS)) begin
                d.rresp = RESP_OKAY;
                d.rdata = {26'h0000_0000, q.out_b, q.out_a};
            end
            for (int g = 0; g < NUM_GEN; g++) begin
                if (s_axi_araddr == ADDR_W'(OFF_GEN_A[g])) begin
                    d.rresp = RESP_OKAY;
                    d.rdata = {20'h0_0000, q.act_a[g]};
                end
                if (s_axi_araddr == ADDR_W'(OFF_GEN_B[g])) begin
                    d.rresp = RESP_OKAY;
                    d.rdata = {20'h0_0000, q.act_b[g]};
                end
            end
        end
        for (int g = 0; g < NUM_GEN; g++) begin
            d.out_a[g] = pwmact_next(q.act_a[g], gen_events[g], q.mode[g], 1'b0, q.out_a[g]);
            d.out_b[g] = pwmact_next(q.act_b[g], gen_events[g], q.mode[g], 1'b1, q.out_b[g]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign s_axi_bvalid       = q.bvalid;
    assign s_axi_bresp        = q.bresp;
    assign s_axi_rvalid       = q.rvalid;
    assign s_axi_rdata        = q.rdata;
    assign s_axi_rresp        = q.rresp;
    assign generator_output_a = q.out_a;
    assign generator_output_b = q.out_b;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions: generator 0 actions, reset of all outputs, axi handshakes

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    reset_clears_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> (generator_output_a == 3'h0) && (generator_output_b == 3'h0))
        else $error("outputs not low after reset");

    zero_sets_high_a: assert property (
        gen_events[0].zero && q.act_a[0][FLD_ZERO +: 2] == ACT_HIGH |=> generator_output_a[0])
        else $error("zero action high not applied");

    load_inverts_a: assert property (
        gen_events[0].load && !gen_events[0].zero && q.act_a[0][FLD_LOAD +: 2] == ACT_INV
        |=> generator_output_a[0] != $past(generator_output_a[0]))
        else $error("load invert not applied");

    zero_beats_cmp_a: assert property (
        gen_events[0].zero && gen_events[0].cmp_a && q.act_a[0][FLD_ZERO +: 2] == ACT_LOW
        |=> !generator_output_a[0])
        else $error("comparator action beat zero action");

    b_prefers_cmpb_a: assert property (
        !gen_events[0].zero && !gen_events[0].load && gen_events[0].cmp_a && gen_events[0].cmp_b
        && !q.mode[0] && q.act_b[0][FLD_BD +: 2] == ACT_HIGH |=> generator_output_b[0])
        else $error("B output did not take comparator B action");

    a_prefers_cmpa_a: assert property (
        !gen_events[0].zero && !gen_events[0].load && gen_events[0].cmp_a && gen_events[0].cmp_b
        && !q.mode[0] && q.act_a[0][FLD_AD +: 2] == ACT_LOW |=> !generator_output_a[0])
        else $error("A output did not take comparator A action");

    up_cmp_field_a: assert property (
        !gen_events[0].zero && !gen_events[0].load && gen_events[0].cmp_a && !gen_events[0].cmp_b
        && q.mode[0] && !gen_events[0].down && q.act_a[0][FLD_AU +: 2] == ACT_NONE
        |=> $stable(generator_output_a[0]))
        else $error("up compare A used wrong field");

    down_only_mode_a: assert property (
        !gen_events[0].zero && !gen_events[0].load && gen_events[0].cmp_b && !gen_events[0].cmp_a
        && !q.mode[0] && q.act_b[0][FLD_BD +: 2] == ACT_HIGH |=> generator_output_b[0])
        else $error("down-only compare B not taken as down event");

    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response missing");

    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");

endmodule : pwmact_top
`default_nettype wire

// ### hw/pwmact_pkg.sv
// package for the pwm output action logic: offsets, field layout, encodings, events
package pwmact_pkg;

    localparam int NUM_GEN = 3;

    // register byte offsets
    localparam logic [2:0][11:0] OFF_GEN_A   = {12'h0E0, 12'h0A0, 12'h060};
    localparam logic [2:0][11:0] OFF_GEN_B   = {12'h0E4, 12'h0A4, 12'h064};
    localparam logic [11:0]      OFF_MODE    = 12'h0F0;
    localparam logic [11:0]      OFF_STATUS  = 12'h0F4;

    // action field positions within an action register
    localparam int FLD_ZERO = 0;
    localparam int FLD_LOAD = 2;
    localparam int FLD_AU   = 4;
    localparam int FLD_AD   = 6;
    localparam int FLD_BU   = 8;
    localparam int FLD_BD   = 10;
    localparam int CTL_W    = 12;

    // reset values
    localparam logic [CTL_W-1:0] CTL_RST  = 12'h000;
    localparam logic [2:0]       MODE_RST = 3'h0;

    // action encodings
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_INV  = 2'h1;
    localparam logic [1:0] ACT_LOW  = 2'h2;
    localparam logic [1:0] ACT_HIGH = 2'h3;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // counter and comparator events of one generator, one-cycle pulses
    typedef struct packed {
        logic zero;
        logic load;
        logic cmp_a;
        logic cmp_b;
        logic down;
    } pwmact_evt_t;

endpackage : pwmact_pkg

// ### sim/tb_top.sv
// self-checking bench for the pwm output action logic
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import pwmact_pkg::*;
;
    logic                      aclk, aresetn;
    logic [11:0]               awaddr, araddr;
    logic [31:0]               wdata, rdata, rd_q;
    logic [3:0]                wstrb;
    logic                      awvalid, awready, wvalid, wready, bvalid, bready;
    logic                      arvalid, arready, rvalid, rready;
    logic [1:0]                bresp, rresp, rs_q;
    pwmact_evt_t [NUM_GEN-1:0] ev;
    logic [NUM_GEN-1:0]        out_a, out_b, exp_a, exp_b;
    logic [2:0]                mode;
    // one action set per pass, one word per generator
    logic [11:0]               cfg_a [3][3] = '{'{12'hB6D, 12'h4E7, 12'hE1B},
                                                '{12'hD87, 12'h1B4, 12'h6F0},
                                                '{12'h2DE, 12'h8A9, 12'hC57}};
    logic [11:0]               cfg_b [3][3] = '{'{12'hDB6, 12'h9E1, 12'h7C8},
                                                '{12'h5C9, 12'hE72, 12'h03F},
                                                '{12'hA36, 12'h4D8, 12'hF1C}};
    int                        failures = 0;
    int                        n_tests  = 0;
    ////////////////////////////////////////////////////////////////////////////////
    pwmact_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gen_events(ev),
        .generator_output_a(out_a), .generator_output_b(out_b));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("errors=%0d compares=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // ready is looked at on the falling edge so the rising edge that follows is the handshake
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(awready && wready)) @(negedge aclk);
        @(posedge aclk);
        awvalid <= 1'b0; wvalid <= 1'b0;
        while (!bvalid) @(negedge aclk);
        rs_q = bresp;
        @(posedge aclk);
        bready <= 1'b0;
        chk({30'h0, rs_q}, {30'h0, r});
    endtask : axi_write
    task automatic axi_read(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!arready) @(negedge aclk);
        @(posedge aclk);
        arvalid <= 1'b0;
        while (!rvalid) @(negedge aclk);
        rd_q = rdata; rs_q = rresp;
        @(posedge aclk);
        rready <= 1'b0;
        chk(rd_q, d);
        chk({30'h0, rs_q}, {30'h0, r});
    endtask : axi_read
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] pick(input logic [11:0] c, input pwmact_evt_t e, input logic ud, input logic isb);
        logic up;
        up = ud & ~e.down;
        if (e.zero) return c[1:0];
        if (e.load) return c[3:2];
        if (e.cmp_a && (!e.cmp_b || !isb)) return up ? c[5:4] : c[7:6];
        if (e.cmp_b) return up ? c[9:8] : c[11:10];
        return ACT_NONE;
    endfunction : pick
    function automatic logic apply(input logic cur, input logic [1:0] code);
        case (code)
            ACT_INV:  return ~cur;
            ACT_LOW:  return 1'b0;
            ACT_HIGH: return 1'b1;
            default:  return cur;
        endcase
    endfunction : apply
    // one-cycle event pulse on one generator, then all six outputs compared
    task automatic fire(input int p, input int g, input logic [4:0] k);
        pwmact_evt_t e;
        e = pwmact_evt_t'(k);
        @(posedge aclk);
        ev[g] <= e;
        @(posedge aclk);
        ev <= '0;
        exp_a[g] = apply(exp_a[g], pick(cfg_a[p][g], e, mode[g], 1'b0));
        exp_b[g] = apply(exp_b[g], pick(cfg_b[p][g], e, mode[g], 1'b1));
        @(negedge aclk);
        chk({29'h0, out_a}, {29'h0, exp_a});
        chk({29'h0, out_b}, {29'h0, exp_b});
    endtask : fire
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF; awvalid = 1'b0;
        wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0; ev = '0;
        exp_a = '0; exp_b = '0; mode = 3'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({26'h0, out_b, out_a}, 32'h0);
        for (int g = 0; g < NUM_GEN; g++) begin
            axi_read(OFF_GEN_A[g], 32'h0, RESP_OKAY);
            axi_read(OFF_GEN_B[g], 32'h0, RESP_OKAY);
        end
        axi_write(12'h100, 32'h00000FFF, RESP_SLVERR);
        axi_read(12'h100, 32'h0, RESP_SLVERR);
        // three action sets so each field code meets each event kind across the three generators
        for (int p = 0; p < 3; p++) begin
            // upper bits are written nonzero and must read back as zero
            for (int g = 0; g < NUM_GEN; g++) begin
                axi_write(OFF_GEN_A[g], {20'hABCDE, cfg_a[p][g]}, RESP_OKAY);
                axi_write(OFF_GEN_B[g], {20'hABCDE, cfg_b[p][g]}, RESP_OKAY);
            end
            for (int g = 0; g < NUM_GEN; g++) begin
                axi_read(OFF_GEN_A[g], {20'h0, cfg_a[p][g]}, RESP_OKAY);
                axi_read(OFF_GEN_B[g], {20'h0, cfg_b[p][g]}, RESP_OKAY);
            end
            // every event combination on every generator, down-only first, then up/down
            // the middle pass mixes modes so each generator follows its own mode bit
            for (int m = 0; m < 2; m++) begin
                mode = (m == 1) ? ((p == 1) ? 3'h5 : 3'h7) : 3'h0;
                axi_write(OFF_MODE, {29'h0, mode}, RESP_OKAY);
                for (int g = 0; g < NUM_GEN; g++)
                    for (int k = 0; k < 32; k++)
                        fire(p, g, k[4:0]);
            end
        end
        axi_read(OFF_STATUS, {26'h0, exp_b, exp_a}, RESP_OKAY);
        // single byte lanes: lane 1 carries bits 11:8, lane 0 bits 7:0
        wstrb <= 4'h2;
        axi_write(OFF_GEN_A[1], 32'h0000_0355, RESP_OKAY);
        axi_read(OFF_GEN_A[1], 32'h0000_03A9, RESP_OKAY);
        wstrb <= 4'h1;
        axi_write(OFF_GEN_A[1], 32'h0000_0C66, RESP_OKAY);
        axi_read(OFF_GEN_A[1], 32'h0000_0366, RESP_OKAY);
        wstrb <= 4'hF;
        wrap_up();
    end
    // whole run needs about 1330 cycles; the limit allows 10000
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
